// ### dv/cfg_front_monitor.sv
/* Port checker for cfg_front.
 Assumes one sys_clk domain. */
`timescale 1ns/1ps
module cfg_front_monitor (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic core_pll_ok,
	input wire logic config_request_n,
	input wire logic frame_error,
	input wire logic data_ready,
	input wire logic cell_write,
	input wire logic user_mode,
	input wire logic status_open_drain_n_oe,
	input wire logic config_complete_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_req;
		!config_request_n |-> ##[1:2] status_open_drain_n_oe;
	endproperty
	a_req: assert property (p_req) else $error("request low");
	property p_brown;
		$fell(core_pll_ok) && !status_open_drain_n_oe |-> ##[1:2] status_open_drain_n_oe;
	endproperty
	a_brown: assert property (p_brown) else $error("brown-out");
	property p_err;
		frame_error && data_ready |-> ##[1:2] (status_open_drain_n_oe && config_complete_oe);
	endproperty
	a_err: assert property (p_err) else $error("error");
	property p_ready;
		data_ready |-> !status_open_drain_n_oe && config_complete_oe;
	endproperty
	a_ready: assert property (p_ready) else $error("ready");
	property p_user;
		user_mode |-> !config_complete_oe && !status_open_drain_n_oe;
	endproperty
	a_user: assert property (p_user) else $error("user mode");
	// Three held cycles drain the one-stage write pipe
	property p_drain;
		status_open_drain_n_oe [*3] |-> !cell_write;
	endproperty
	a_drain: assert property (p_drain) else $error("write");
	property p_done;
		!config_complete_oe && config_request_n && core_pll_ok |=> !config_complete_oe;
	endproperty
	a_done: assert property (p_done) else $error("done");
	property p_hold;
		$rose(config_complete_oe) |-> !config_request_n || !core_pll_ok || !$past(core_pll_ok);
	endproperty
	a_hold: assert property (p_hold) else $error("complete");
endmodule
bind cfg_front cfg_front_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n),
	.core_pll_ok(core_pll_ok), .config_request_n(config_request_n),
	.frame_error(frame_error), .data_ready(data_ready), .cell_write(cell_write),
	.user_mode(user_mode), .status_open_drain_n_oe(status_open_drain_n_oe),
	.config_complete_oe(config_complete_oe));

// ### dv/cfg_host.sv
/* Host model: request line and byte stream.
 Assumes tasks start just after a clock edge. */
`timescale 1ns/1ps
module cfg_host (
	input wire logic sys_clk,
	input wire logic data_ready,
	output logic data_valid,
	output logic [7:0] data_in,
	output logic config_request_n
);
	initial begin
		data_valid = 1'b0;
		data_in = 8'h00;
		config_request_n = 1'b0; // Low until supplies settle
	end
	task automatic restart();
		config_request_n <= 1'b0;
		repeat (63) @(posedge sys_clk); // 504 ns low
		config_request_n <= 1'b1;
	endtask
	task automatic stream(input logic [7:0] q[$], input int slow);
		foreach (q[i]) begin
			data_valid <= 1'b1;
			data_in <= q[i];
			do @(posedge sys_clk); while (data_ready !== 1'b1);
			if (slow > 0) begin
				data_valid <= 1'b0;
				data_in <= ~q[i];
				repeat (slow) @(posedge sys_clk);
			end
		end
		data_valid <= 1'b0;
		if (slow == 0) data_in <= ~data_in;
	endtask
endmodule

// ### dv/tb_top.sv
/* Bench for cfg_front.
 Assumes pull-ups on both open-drain lines. */
`timescale 1ns/1ps
`include "cfg_front_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_top;
	int n_errors = 0;
	int n_tests = 0;
	logic sys_clk, rst_n, supplies_ok, core_pll_ok, scheme_select, compress_en, frame_error;
	logic data_valid, data_ready, cell_write, user_mode, config_request_n, st_oe, cc_oe;
	logic auto_restart_en;
	logic [31:0] frame_count;
	logic [7:0] data_in, cell_data;
	wire st_lvl = !st_oe;
	wire cc_lvl = !cc_oe;
	cfg_front dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .supplies_ok(supplies_ok),
		.core_pll_ok(core_pll_ok), .scheme_select(scheme_select), .compress_en(compress_en),
		.auto_restart_en(auto_restart_en), .config_request_n(config_request_n),
		.frame_count(frame_count),
		.data_valid(data_valid), .data_ready(data_ready), .data_in(data_in),
		.frame_error(frame_error), .cell_write(cell_write), .cell_data(cell_data),
		.user_mode(user_mode), .status_open_drain_n_in(st_lvl), .status_open_drain_n_out(),
		.status_open_drain_n_oe(st_oe), .config_complete_in(cc_lvl),
		.config_complete_out(), .config_complete_oe(cc_oe));
	cfg_host host (.sys_clk(sys_clk), .data_ready(data_ready), .data_valid(data_valid),
		.data_in(data_in), .config_request_n(config_request_n));
	task automatic wait_rel(output int n);
		n = 0;
		while (st_oe !== 1'b0 && n < 40000) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	task automatic power_up(input logic fast, input int cyc);
		int n;
		rst_n <= 1'b0;
		supplies_ok <= 1'b0;
		scheme_select <= fast;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (20) @(posedge sys_clk);
		`CHK("status held", 1'b1, st_oe)
		supplies_ok <= 1'b1;
		host.restart();
		wait_rel(n);
		`CHK("por delay", 1'b1, n + 63 >= cyc && n + 63 < cyc + 16)
	endtask
	task automatic load(input logic c, input int slow, input logic [7:0] q[$], e[$]);
		int n;
		compress_en <= c;
		frame_count <= e.size();
		host.restart();
		wait_rel(n);
		`CHK("ready", 1'b1, n < 8)
		fork
			host.stream(q, slow);
			foreach (e[i]) begin
				n = 0;
				do begin
					@(posedge sys_clk);
					n++;
				end while (cell_write !== 1'b1 && n < 50);
				`CHK("cell data", e[i], cell_data)
			end
		join
		repeat (3) @(posedge sys_clk);
		`CHK("complete", 1'b0, cc_oe)
		`CHK("user mode", 1'b1, user_mode)
	endtask
	task automatic fault();
		int n;
		core_pll_ok <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK("brown-out", 2'b11, {st_oe, cc_oe})
		core_pll_ok <= 1'b1;
		host.restart();
		wait_rel(n);
		frame_error <= 1'b1;
		@(posedge sys_clk);
		frame_error <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK("error", 2'b11, {st_oe, cc_oe})
		wait_rel(n);
		`CHK("retry", 1'b1, n + 3 <= `RESTART_CYC && n + 16 > `RESTART_CYC)
		auto_restart_en <= 1'b0;
		frame_error <= 1'b1;
		@(posedge sys_clk);
		frame_error <= 1'b0;
		repeat (100) @(posedge sys_clk);
		`CHK("no restart", 1'b1, st_oe)
		auto_restart_en <= 1'b1;
		host.restart();
		wait_rel(n);
		`CHK("manual restart", 1'b1, n < 8)
	endtask
	task automatic test_done();
		if (n_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		rst_n = 1'b0;
		supplies_ok = 1'b0;
		core_pll_ok = 1'b1;
		auto_restart_en = 1'b1;
		scheme_select = 1'b1;
		compress_en = 1'b0;
		frame_error = 1'b0;
		frame_count = 32'h0000_0000;
		power_up(1'b1, `POR_FAST_CYC);
		load(1'b0, 2, {8'h83, 8'h5a, 8'h11, 8'h80, 8'h22}, {8'h83, 8'h5a, 8'h11, 8'h80, 8'h22});
		load(1'b1, 0, {8'h83, 8'h5a, 8'h11, 8'h80, 8'h22}, {8'h5a, 8'h5a, 8'h5a, 8'h11, 8'h22});
		fault();
		power_up(1'b0, `POR_STD_CYC);
		test_done();
	end
	// Whole run needs about 32000 cycles
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_errors++;
		test_done();
	end
endmodule

// ### logic/cfg_front.sv
/*
 Configuration loader front end: power-on reset timing, reset and
 status lines, and the real-time decompressor feeding the cells.
 Assumes supply monitors and pins are synchronous to sys_clk and the
 host keeps config_request_n low while supplies are unsettled.
*/
// Contract
// - Fresh full download required after every power-up
// - Hold status low until supplies valid
// - Brown-out after power-up acts as reset
// - Strap picks fast or standard reset delay
// - Decompress stream on the fly into cells
// - Decompressor outpaces incoming stream, never stalls; runs queue input in the FIFO and data_ready drops when full
// - Per-device compression; host sends matching form
// - Request low keeps reset; high releases status
// - Error: status low, auto-restart within 230 us
// - Release complete line after all data
`timescale 1ns/1ps
`include "cfg_front_consts.svh"
module cfg_front (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic supplies_ok,
	input wire logic core_pll_ok,
	input wire logic scheme_select,
	input wire logic compress_en,
	input wire logic auto_restart_en,
	input wire logic config_request_n,
	input wire logic [31:0] frame_count,
	input wire logic data_valid,
	output logic data_ready,
	input wire logic [`DATA_WIDTH-1:0] data_in,
	input wire logic frame_error,
	output logic cell_write,
	output logic [`DATA_WIDTH-1:0] cell_data,
	output logic user_mode,
	input wire logic status_open_drain_n_in,
	output logic status_open_drain_n_out,
	output logic status_open_drain_n_oe,
	input wire logic config_complete_in,
	output logic config_complete_out,
	output logic config_complete_oe
);
	import cfg_front_pkg::*;

	logic rst_s1_q, rst_s2_q;
	load_state_t state_q, state_d;
	logic [`CNT_WIDTH-1:0] tmr_q, tmr_d;
	logic [31:0] words_q, words_d;
	logic [`DATA_WIDTH-1:0] run_byte_q, run_byte_d, cell_data_q, cell_data_d;
	logic [6:0] run_left_q, run_left_d;
	logic run_pend_q, run_pend_d;
	logic cell_write_q, cell_write_d;
	logic f_valid, f_ready, f_pop;
	logic [`DATA_WIDTH-1:0] f_data;
	logic flush;

	////////////////////////////////////////////////////////////////////
	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	function automatic logic [`CNT_WIDTH-1:0] por_delay(input logic fast);
		por_delay = fast ? `CNT_WIDTH'(`POR_FAST_CYC) : `CNT_WIDTH'(`POR_STD_CYC);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Input FIFO; drained every cycle it is not expanding a run
	assign flush = state_q != ST_LOAD;
	stream_fifo #(.WIDTH(`DATA_WIDTH), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
		.clk(sys_clk),
		.rst_n(rst_s2_q),
		.ce(clk_en),
		.flush(flush),
		.in_valid(data_valid && state_q == ST_LOAD),
		.in_ready(f_ready),
		.in_data(data_in),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);
	assign data_ready = f_ready && state_q == ST_LOAD;

	////////////////////////////////////////////////////////////////////
	// Load sequencer and decompressor
	always_comb begin
		state_d = state_q;
		tmr_d = tmr_q;
		words_d = words_q;
		run_byte_d = run_byte_q;
		run_left_d = run_left_q;
		run_pend_d = run_pend_q;
		cell_data_d = cell_data_q;
		cell_write_d = 1'b0;
		f_pop = 1'b0;
		unique case (state_q)
			ST_POR: begin
				// Delay counts only while supplies are good
				if (!supplies_ok) begin
					tmr_d = por_delay(scheme_select);
				end else if (tmr_q != '0) begin
					tmr_d = tmr_q - `CNT_WIDTH'(1);
				end else begin
					state_d = ST_RESET;
				end
			end
			ST_RESET: begin
				// Any leftover progress is discarded
				words_d = '0;
				run_left_d = '0;
				run_pend_d = 1'b0;
				if (config_request_n) begin
					state_d = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (frame_error) begin
					state_d = ST_ERROR;
					// Three edges beyond the countdown pass from the error to status release
					tmr_d = `CNT_WIDTH'(`RESTART_CYC - 3);
				end else if (words_q == frame_count) begin
					state_d = ST_DONE;
				end else if (run_left_q != '0) begin
					// Run expansion; one cell per cycle while input waits in the FIFO
					cell_data_d = run_byte_q;
					cell_write_d = 1'b1;
					words_d = words_q + 32'd1;
					run_left_d = run_left_q - 7'd1;
				end else if (f_valid) begin
					f_pop = 1'b1;
					if (!compress_en) begin
						cell_data_d = f_data;
						cell_write_d = 1'b1;
						words_d = words_q + 32'd1;
					end else if (run_pend_q) begin
						run_byte_d = f_data;
						run_pend_d = 1'b0;
					end else if (f_data[`RUN_CODE_BIT]) begin
						// Code byte: repeat the next byte count times (zero counts as one)
						run_left_d = f_data[6:0] + 7'd0;
						run_pend_d = 1'b1;
						if (f_data[6:0] == 7'd0) begin
							run_left_d = 7'd1;
						end
					end else begin
						cell_data_d = f_data;
						cell_write_d = 1'b1;
						words_d = words_q + 32'd1;
					end
				end
			end
			ST_ERROR: begin
				if (auto_restart_en) begin
					if (tmr_q != '0) begin
						tmr_d = tmr_q - `CNT_WIDTH'(1);
					end else begin
						state_d = ST_RESET;
					end
				end
			end
			ST_DONE: begin
			end
			default: begin
				state_d = ST_POR;
			end
		endcase
		// Run is held until its value byte arrives
		if (run_pend_q && run_left_q != '0 && state_q == ST_LOAD && !frame_error
				&& words_q != frame_count && !f_valid) begin
			cell_write_d = 1'b0;
			words_d = words_q;
			run_left_d = run_left_q;
			cell_data_d = cell_data_q;
		end
		if (run_pend_q && run_left_q != '0 && state_q == ST_LOAD && f_valid
				&& !frame_error && words_q != frame_count) begin
			cell_write_d = 1'b0;
			words_d = words_q;
			run_left_d = run_left_q;
			cell_data_d = cell_data_q;
			f_pop = 1'b1;
			run_byte_d = f_data;
			run_pend_d = 1'b0;
		end
		// Request low or brown-out overrides every state but ST_POR
		if (state_q != ST_POR && !core_pll_ok) begin
			state_d = ST_POR;
			tmr_d = por_delay(scheme_select);
		end else if (state_q != ST_POR && !config_request_n) begin
			state_d = ST_RESET;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			state_q <= ST_POR;
			tmr_q <= `CNT_WIDTH'(`POR_STD_CYC);
			words_q <= '0;
			run_byte_q <= '0;
			run_left_q <= '0;
			run_pend_q <= 1'b0;
			cell_data_q <= '0;
			cell_write_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			words_q <= words_d;
			run_byte_q <= run_byte_d;
			run_left_q <= run_left_d;
			run_pend_q <= run_pend_d;
			cell_data_q <= cell_data_d;
			cell_write_q <= cell_write_d && clk_en;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Open-drain lines: drive low only, never high
	assign status_open_drain_n_out = 1'b0;
	assign status_open_drain_n_oe = state_q == ST_POR || state_q == ST_RESET
		|| state_q == ST_ERROR;
	assign config_complete_out = 1'b0;
	assign config_complete_oe = state_q != ST_DONE;
	assign cell_write = cell_write_q;
	assign cell_data = cell_data_q;
	assign user_mode = state_q == ST_DONE && config_complete_in;
endmodule

// ### logic/cfg_front_consts.svh
/*
 Timing counts and widths for the configuration loader front end.
 Assumes a 125 MHz sys_clk.
*/
`ifndef CFG_FRONT_CONSTS_SVH
`define CFG_FRONT_CONSTS_SVH

`define CLK_PERIOD_PS 8000
`define DATA_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define POR_FAST_NS 2000
`define POR_STD_NS 20000
`define POR_FAST_CYC ((`POR_FAST_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define POR_STD_CYC ((`POR_STD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESTART_US 230
`define RESTART_CYC ((`RESTART_US * 1000000) / `CLK_PERIOD_PS)
`define CNT_WIDTH 16
`define RUN_CODE_BIT 7

`endif

// ### logic/cfg_front_pkg.sv
/*
 Types for the configuration loader front end.
 Assumes the constants header is included beside it.
*/
package cfg_front_pkg;
	typedef enum logic [2:0] {
		ST_POR = 3'b000,
		ST_RESET = 3'b001,
		ST_LOAD = 3'b010,
		ST_ERROR = 3'b011,
		ST_DONE = 3'b100
	} load_state_t;
endpackage

// ### logic/stream_fifo.sv
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock, active-low async reset, clock enable.
*/
`timescale 1ns/1ps
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic push, pop;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
		out_valid = wr_q != rd_q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_d = flush ? '0 : wr_q + (AW+1)'(push);
		rd_d = flush ? '0 : rd_q + (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (ce) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// Storage has no reset; words are only read once written
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	// Read data is presented combinationally from the head slot
	assign out_data = mem_q[rd_q[AW-1:0]];
endmodule
